/* File: ssp_top.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Control one is 16-bit read/write, resets zero, fixed field layout.
// - Interface-off clears flags and parks pins per master or slave role.
// - Master select zero means slave, one means bus master.
// - Word size picks 8 or 16 bits; change only when idle.
// - Slave echo resends master-out bits when no valid transmit data.
// - Data register is valid from write until its transfer ends.
// - Overrun enable raises interrupt while overrun flag is set.
// - Read-full enable raises interrupt while read buffer is full.
// - Transfer-done enable raises interrupt once busy has cleared.
// - Phase zero drives on falling, samples rising; phase one reversed.
// - Idle level sets shift clock level outside transfers.
// - Master shift clock is input clock over two times (divider plus one).
// - Control two resets zero; bits enable receive and transmit DMA requests.
// - Status is 3-bit, read-only except overrun, resets clear.
// - Busy sets on data write, or slave leading edge with select.
// - Busy clears when transfer done and read buffer free, when a data read takes a waiting word, or when the interface is off.
// - Completed word moves into an empty read buffer, setting read-full.
// - Data read clears read-full unless new word waits; then reloads.
// - Master overrun sets on start with both buffers full; write one clears.
// - Master emits eight or sixteen clocks per write, then idles.
// - Slave shifts and drives only with select low, MSB first.
module ssp_top #(
    parameter int unsigned AW = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [AW-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic pslverr_out,
    output logic [31:0] prdata_out,
    // Serial pins
    input wire logic shift_clock_pin_in,
    output logic shift_clock_pin_out,
    output logic shift_clock_pin_oe_out,
    input wire logic slave_out_pin_in,
    output logic slave_out_pin_out,
    output logic slave_out_pin_oe_out,
    input wire logic master_out_pin_in,
    output logic master_out_pin_out,
    output logic master_out_pin_oe_out,
    input wire logic slave_select_pin_n_in,
    // Requests
    output logic irq_out,
    output logic dma_rx_req_out,
    output logic dma_tx_req_out
);
    logic [15:0] ctl1_q;
    logic [1:0] ctl2_q;
    logic bsy_q, bsy_d, rbf_q, rbf_d, ovr_q;
    logic [15:0] rbuf_q, tx_q, rx_q;
    logic full_q, full_d, valid_q, done_q;
    logic [4:0] bitcnt_q, tog_q;
    logic [6:0] divcnt_q;
    logic mclk_q, sclk_prev_q;
    ssp_pkg::ssp_gen_t gen_q;
    logic pready_q, pslverr_q, irq_q, dma_rx_q, dma_tx_q;
    logic [31:0] prdata_q;
    logic so_out_q, so_oe_q, mo_out_q, mo_oe_q, sclk_oe_q;

    // Control field views
    logic on, ms, ws, echo, ph, idl;
    logic [6:0] div;
    assign on = ctl1_q[ssp_pkg::C1_ON];
    assign ms = ctl1_q[ssp_pkg::C1_MS];
    assign ws = ctl1_q[ssp_pkg::C1_WS];
    assign echo = ctl1_q[ssp_pkg::C1_ECHO];
    assign ph = ctl1_q[ssp_pkg::C1_PH];
    assign idl = ctl1_q[ssp_pkg::C1_IDL];
    assign div = ctl1_q[ssp_pkg::C1_DIV_MSB:ssp_pkg::C1_DIV_LSB];

    // Address decode
    logic [3:0] idx;
    logic upper_zero, hit_data, hit_ctl1, hit_stat, hit_ctl2, mapped;
    logic acc, wr, rd, wr_data, rd_data;
    assign idx = paddr_in[ssp_pkg::IDX_MSB:ssp_pkg::IDX_LSB];
    assign upper_zero = (paddr_in[AW-1:ssp_pkg::IDX_MSB+1] == '0);
    assign hit_data = upper_zero && (idx == ssp_pkg::IDX_DATA);
    assign hit_ctl1 = upper_zero && (idx == ssp_pkg::IDX_CTL1);
    assign hit_stat = upper_zero && (idx == ssp_pkg::IDX_STAT);
    assign hit_ctl2 = upper_zero && (idx == ssp_pkg::IDX_CTL2);
    assign mapped = hit_data | hit_ctl1 | hit_stat | hit_ctl2;
    assign acc = psel_in & penable_in & pready_q;
    assign wr = acc & pwrite_in;
    assign rd = acc & ~pwrite_in;
    assign wr_data = wr & hit_data;
    assign rd_data = rd & hit_data;

    // Shift clock events
    logic m_edge, m_rise, m_fall, s_act, s_rise, s_fall;
    logic rise, fall, samp, drv, s_lead, in_bit, start_m;
    logic last_samp, done_ev, echo_act;
    logic [4:0] last_bit, last_tog;
    logic [15:0] rx_word, tx_load;
    assign m_edge = (gen_q == ssp_pkg::SSP_GEN_RUN) && (divcnt_q == div);
    assign m_rise = m_edge & ~mclk_q;
    assign m_fall = m_edge & mclk_q;
    assign s_act = on & ~ms & ~slave_select_pin_n_in;
    assign s_rise = s_act & shift_clock_pin_in & ~sclk_prev_q;
    assign s_fall = s_act & ~shift_clock_pin_in & sclk_prev_q;
    assign rise = ms ? m_rise : s_rise;
    assign fall = ms ? m_fall : s_fall;
    assign samp = ph ? fall : rise;
    assign drv = ph ? rise : fall;
    assign s_lead = idl ? s_fall : s_rise;
    assign in_bit = ms ? slave_out_pin_in : master_out_pin_in;
    assign last_bit = ws ? ssp_pkg::LAST16 : ssp_pkg::LAST8;
    assign last_tog = ws ? ssp_pkg::TOG16 : ssp_pkg::TOG8;
    assign last_samp = samp && (bitcnt_q == last_bit);
    assign done_ev = ms ? (m_edge && (tog_q == last_tog)) : last_samp;
    assign start_m = wr_data & on & ms & (gen_q == ssp_pkg::SSP_GEN_IDLE);
    assign rx_word = ws ? rx_q : {8'h00, rx_q[7:0]};
    assign tx_load = ws ? pwdata_in[15:0] : {pwdata_in[7:0], 8'h00};
    assign echo_act = ~ms & echo & ~valid_q;

    // APB answer one cycle into the access phase
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else if (psel_in && penable_in && !pready_q)
        begin
            pready_q <= 1'b1;
            pslverr_q <= ~mapped;
            if (hit_data)
                prdata_q <= {16'h0000, rbuf_q};
            else if (hit_ctl1)
                prdata_q <= {16'h0000, ctl1_q};
            else if (hit_stat)
                prdata_q <= {29'h00000000, ovr_q, rbf_q, bsy_q};
            else if (hit_ctl2)
                prdata_q <= {30'h00000000, ctl2_q};
            else
                prdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Control registers
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ctl1_q <= ssp_pkg::CTL1_RST;
            ctl2_q <= ssp_pkg::CTL2_RST;
        end
        else
        begin
            if (wr && hit_ctl1)
                ctl1_q <= pwdata_in[15:0];
            if (wr && hit_ctl2)
                ctl2_q <= pwdata_in[1:0];
        end
    end

    // Master clock generator
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            gen_q <= ssp_pkg::SSP_GEN_IDLE;
            divcnt_q <= 7'h00;
            tog_q <= 5'h00;
            mclk_q <= 1'b0;
        end
        else if (!on || !ms)
        begin
            gen_q <= ssp_pkg::SSP_GEN_IDLE;
            mclk_q <= idl;
        end
        else
        begin
            case (gen_q)
                ssp_pkg::SSP_GEN_IDLE:
                begin
                    mclk_q <= idl;
                    divcnt_q <= 7'h00;
                    tog_q <= 5'h00;
                    if (start_m)
                        gen_q <= ssp_pkg::SSP_GEN_RUN;
                end
                ssp_pkg::SSP_GEN_RUN:
                begin
                    if (m_edge)
                    begin
                        divcnt_q <= 7'h00;
                        mclk_q <= ~mclk_q;
                        tog_q <= tog_q + 5'h01;
                        if (tog_q == last_tog)
                            gen_q <= ssp_pkg::SSP_GEN_IDLE;
                    end
                    else
                        divcnt_q <= divcnt_q + 7'h01;
                end
                default:
                    gen_q <= ssp_pkg::SSP_GEN_IDLE;
            endcase
        end
    end

    // Bit counter, shift registers
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            bitcnt_q <= 5'h00;
            rx_q <= ssp_pkg::DATA_RST;
            tx_q <= ssp_pkg::DATA_RST;
            sclk_prev_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            sclk_prev_q <= shift_clock_pin_in;
            done_q <= done_ev & on;
            if (!on || (!ms && slave_select_pin_n_in) || start_m)
                bitcnt_q <= 5'h00;
            else if (last_samp)
                bitcnt_q <= 5'h00;
            else if (samp)
                bitcnt_q <= bitcnt_q + 5'h01;
            if (samp)
                rx_q <= {rx_q[14:0], in_bit};
            if (start_m || (wr_data && !ms && bitcnt_q == 5'h00))
                tx_q <= tx_load;
            else if (drv && bitcnt_q != 5'h00)
                tx_q <= {tx_q[14:0], 1'b0};
        end
    end

    // Flag next values
    logic free, move_done, move_rd;
    assign free = ~rbf_q | (rd_data & ~full_q);
    assign move_done = done_q & free;
    assign move_rd = rd_data & full_q & ~done_q;
    always_comb
    begin
        bsy_d = bsy_q;
        rbf_d = rbf_q;
        full_d = full_q;
        if (move_done)
        begin
            bsy_d = 1'b0;
            rbf_d = 1'b1;
            full_d = 1'b0;
        end
        else if (done_q)
            full_d = 1'b1;
        else if (move_rd)
        begin
            bsy_d = 1'b0;
            full_d = 1'b0;
        end
        else if (rd_data)
            rbf_d = 1'b0;
        if (start_m || (!ms && (wr_data || (s_lead && !done_q))))
            bsy_d = 1'b1;
        if (!on)
        begin
            bsy_d = 1'b0;
            rbf_d = 1'b0;
            full_d = 1'b0;
        end
    end

    // Status and buffers
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            bsy_q <= 1'b0;
            rbf_q <= 1'b0;
            full_q <= 1'b0;
            ovr_q <= 1'b0;
            valid_q <= 1'b0;
            rbuf_q <= ssp_pkg::DATA_RST;
        end
        else
        begin
            bsy_q <= bsy_d;
            rbf_q <= rbf_d;
            full_q <= full_d;
            if (move_done || move_rd)
                rbuf_q <= rx_word;
            if (!on)
                ovr_q <= 1'b0;
            else if (start_m && rbf_q && full_q)
                ovr_q <= 1'b1;
            else if (wr && hit_stat && pwdata_in[ssp_pkg::ST_OVR])
                ovr_q <= 1'b0;
            if (!on)
                valid_q <= 1'b0;
            else if (wr_data)
                valid_q <= 1'b1;
            else if (done_q)
                valid_q <= 1'b0;
        end
    end

    // Pin drivers
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            sclk_oe_q <= 1'b0;
            mo_out_q <= 1'b0;
            mo_oe_q <= 1'b0;
            so_out_q <= 1'b0;
            so_oe_q <= 1'b0;
        end
        else
        begin
            sclk_oe_q <= ms;
            mo_oe_q <= ms;
            mo_out_q <= on & tx_q[15];
            so_oe_q <= s_act;
            so_out_q <= echo_act ? rx_q[0] : tx_q[15];
        end
    end

    // Interrupt and DMA requests
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            irq_q <= 1'b0;
            dma_rx_q <= 1'b0;
            dma_tx_q <= 1'b0;
        end
        else
        begin
            irq_q <= on & ((ctl1_q[ssp_pkg::C1_EIO] & ovr_q)
                | (ctl1_q[ssp_pkg::C1_EIR] & rbf_q)
                | (ctl1_q[ssp_pkg::C1_EIW] & ~bsy_q));
            dma_rx_q <= ctl2_q[ssp_pkg::C2_EDR] & rbf_d & ~rbf_q;
            dma_tx_q <= ctl2_q[ssp_pkg::C2_EDW] & bsy_q & ~bsy_d & on;
        end
    end

    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign prdata_out = prdata_q;
    assign shift_clock_pin_out = mclk_q;
    assign shift_clock_pin_oe_out = sclk_oe_q;
    assign master_out_pin_out = mo_out_q;
    assign master_out_pin_oe_out = mo_oe_q;
    assign slave_out_pin_out = so_out_q;
    assign slave_out_pin_oe_out = so_oe_q;
    assign irq_out = irq_q;
    assign dma_rx_req_out = dma_rx_q;
    assign dma_tx_req_out = dma_tx_q;
endmodule : ssp_top

/* File: ssp_pkg.sv */
package ssp_pkg;
    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_DATA = 4'h0;
    localparam logic [3:0] IDX_CTL1 = 4'h4;
    localparam logic [3:0] IDX_STAT = 4'h8;
    localparam logic [3:0] IDX_CTL2 = 4'ha;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 5;
    // Control one fields
    localparam int C1_ON = 0;
    localparam int C1_MS = 1;
    localparam int C1_WS = 2;
    localparam int C1_ECHO = 3;
    localparam int C1_EIO = 4;
    localparam int C1_EIR = 5;
    localparam int C1_EIW = 6;
    localparam int C1_PH = 7;
    localparam int C1_IDL = 8;
    localparam int C1_DIV_LSB = 9;
    localparam int C1_DIV_MSB = 15;
    // Control two fields
    localparam int C2_EDR = 0;
    localparam int C2_EDW = 1;
    // Status fields
    localparam int ST_BSY = 0;
    localparam int ST_RBF = 1;
    localparam int ST_OVR = 2;
    // Reset values
    localparam logic [15:0] CTL1_RST = 16'h0000;
    localparam logic [1:0] CTL2_RST = 2'h0;
    localparam logic [15:0] DATA_RST = 16'h0000;
    // Bit and edge counts per word size
    localparam logic [4:0] LAST8 = 5'h07;
    localparam logic [4:0] LAST16 = 5'h0f;
    localparam logic [4:0] TOG8 = 5'h0f;
    localparam logic [4:0] TOG16 = 5'h1f;
    // Master clock generator states
    typedef enum logic [1:0] {
        SSP_GEN_IDLE = 2'b01,
        SSP_GEN_RUN = 2'b10
    } ssp_gen_t;
endpackage : ssp_pkg

/* File: ssp_top_sva.sv */
`timescale 1ns/100ps
module ssp_top_sva #(
    parameter int unsigned AW = 8
) (
    // Clock, reset and bus
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [AW-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic pready_out,
    // Pins and requests
    input wire logic shift_clock_pin_out,
    input wire logic shift_clock_pin_oe_out,
    input wire logic slave_out_pin_oe_out,
    input wire logic master_out_pin_out,
    input wire logic master_out_pin_oe_out,
    input wire logic slave_select_pin_n_in,
    input wire logic irq_out,
    input wire logic dma_rx_req_out,
    input wire logic dma_tx_req_out
);
    logic [15:0] c1_q;
    logic [1:0] c2_q;
    logic [5:0] tog_q;
    logic sck_q, wr, on, ms;
    assign wr = psel_in && penable_in && pready_out && pwrite_in;
    assign on = c1_q[ssp_pkg::C1_ON];
    assign ms = c1_q[ssp_pkg::C1_MS];
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    // Software view of the controls
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            c1_q <= 16'h0000;
            c2_q <= 2'h0;
        end
        else if (wr && paddr_in[5:2] == ssp_pkg::IDX_CTL1)
            c1_q <= pwdata_in[15:0];
        else if (wr && paddr_in[5:2] == ssp_pkg::IDX_CTL2)
            c2_q <= pwdata_in[1:0];
    end
    // Shift clock toggles since the last data write
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            tog_q <= 6'h00;
            sck_q <= 1'b0;
        end
        else
        begin
            sck_q <= shift_clock_pin_out;
            if (wr && paddr_in[5:2] == ssp_pkg::IDX_DATA)
                tog_q <= 6'h00;
            else if (sck_q != shift_clock_pin_out && on && ms && tog_q != 6'h3f)
                tog_q <= tog_q + 6'h01;
        end
    end
    sequence setup_s;
        psel_in && !penable_in;
    endsequence
    sequence answer_s;
        !pready_out ##1 pready_out;
    endsequence
    chk_apb_wait: assert property (setup_s |=> answer_s)
        else $error("bus answer not after one wait");
    chk_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready held");
    chk_off_idle: assert property (ms && !on && $stable(c1_q) |=>
        shift_clock_pin_out == $past(c1_q[ssp_pkg::C1_IDL])) else $error("clock not idle");
    chk_off_mo: assert property (ms && !on && $stable(c1_q) |=>
        master_out_pin_oe_out && !master_out_pin_out) else $error("master out unknown");
    chk_role_oe: assert property ($stable(c1_q) |->
        shift_clock_pin_oe_out == ms && master_out_pin_oe_out == ms) else $error("role pins");
    chk_slave_tristate: assert property ((!ms && slave_select_pin_n_in) [*2] |=>
        !slave_out_pin_oe_out) else $error("slave out driven");
    chk_slave_off: assert property (!on [*2] |=> !slave_out_pin_oe_out)
        else $error("slave out driven while off");
    chk_irq_quiet: assert property ($stable(c1_q) && (!on || c1_q[6:4] == 3'h0) |=>
        !irq_out) else $error("interrupt without enable");
    chk_dma_rx: assert property (dma_rx_req_out |-> c2_q[ssp_pkg::C2_EDR] ##1
        !dma_rx_req_out) else $error("rx request");
    chk_dma_tx: assert property (dma_tx_req_out |-> c2_q[ssp_pkg::C2_EDW] ##1
        !dma_tx_req_out) else $error("tx request");
    chk_clock_count: assert property (ms |->
        tog_q <= (c1_q[ssp_pkg::C1_WS] ? 6'h20 : 6'h10)) else $error("too many clocks");
endmodule : ssp_top_sva

bind ssp_top ssp_top_sva #(.AW(AW)) ssp_top_sva_inst (
    .clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pready_out(pready_out), .shift_clock_pin_out(shift_clock_pin_out),
    .shift_clock_pin_oe_out(shift_clock_pin_oe_out),
    .slave_out_pin_oe_out(slave_out_pin_oe_out), .master_out_pin_out(master_out_pin_out),
    .master_out_pin_oe_out(master_out_pin_oe_out),
    .slave_select_pin_n_in(slave_select_pin_n_in), .irq_out(irq_out),
    .dma_rx_req_out(dma_rx_req_out), .dma_tx_req_out(dma_tx_req_out)
);

/* File: ssp_peer_model.sv */
`timescale 1ns/100ps
module ssp_peer_model (
    // Serial lines
    input wire logic sck_in,
    input wire logic mo_in,
    output logic so_out,
    input wire logic sel_n_in,
    // Bench controls
    input wire logic phase_in,
    input wire logic wide_in,
    input wire logic [15:0] reply_in,
    output logic [15:0] got_out
);
    logic [4:0] cnt_q = 5'h00;
    logic [4:0] nb;
    logic so_q = 1'b0;
    assign nb = wide_in ? 5'h10 : 5'h08;
    // Leading bit waits on the line before any edge
    assign so_out = (cnt_q == 5'h00) ? reply_in[nb - 5'h01] : so_q;
    always @(sck_in)
    begin
        // Idle level changes outside a frame must not shift
        if (sel_n_in)
            cnt_q = 5'h00;
        else if (sck_in ^ phase_in)
        begin
            got_out = {got_out[14:0], mo_in};
            cnt_q = (cnt_q + 5'h01 == nb) ? 5'h00 : cnt_q + 5'h01;
        end
        else if (cnt_q != 5'h00)
            so_q = reply_in[nb - 5'h01 - cnt_q];
    end
endmodule : ssp_peer_model

/* File: sync_serial_shift_port_test.sv */
`timescale 1ns/100ps
module sync_serial_shift_port_test;
    localparam logic [7:0] A_DAT = {2'b00, ssp_pkg::IDX_DATA, 2'b00};
    localparam logic [7:0] A_C1 = {2'b00, ssp_pkg::IDX_CTL1, 2'b00};
    localparam logic [7:0] A_ST = {2'b00, ssp_pkg::IDX_STAT, 2'b00};
    localparam logic [7:0] A_C2 = {2'b00, ssp_pkg::IDX_CTL2, 2'b00};
    logic clk_in, rstn_in, psel_in, penable_in, pwrite_in, sck_tb, mo_tb, sel_n, phase, wide;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic pready_out, pslverr_out, sck_o, sck_oe, so_o, so_oe, mo_o, mo_oe, irq, drx, dtx;
    logic sck_w, so_w, mo_w, peer_so;
    logic [15:0] reply, got;
    logic [7:0] so8;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_tog = 0;
    int n_drx = 0;
    int n_dtx = 0;
    realtime t_first, t_half;
    assign sck_w = sck_oe ? sck_o : sck_tb;
    assign mo_w = mo_oe ? mo_o : mo_tb;
    assign so_w = so_oe ? so_o : peer_so;
    ssp_top #(.AW(8)) ssp_top_inst (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .prdata_out(prdata_out), .shift_clock_pin_in(sck_w), .shift_clock_pin_out(sck_o),
        .shift_clock_pin_oe_out(sck_oe), .slave_out_pin_in(so_w), .slave_out_pin_out(so_o),
        .slave_out_pin_oe_out(so_oe), .master_out_pin_in(mo_w), .master_out_pin_out(mo_o),
        .master_out_pin_oe_out(mo_oe), .slave_select_pin_n_in(sel_n), .irq_out(irq),
        .dma_rx_req_out(drx), .dma_tx_req_out(dtx));
    ssp_peer_model ssp_peer_model_inst (.sck_in(sck_w), .mo_in(mo_w), .so_out(peer_so),
        .phase_in(phase), .wide_in(wide), .reply_in(reply), .got_out(got), .sel_n_in(sel_n));
    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    always @(sck_o)
    begin
        n_tog++;
        if (n_tog == 1)
            t_first = $realtime;
        if (n_tog == 2)
            t_half = $realtime - t_first;
    end
    // Request pulses seen
    always @(posedge clk_in)
    begin
        if (drx === 1'b1)
            n_drx++;
        if (dtx === 1'b1)
            n_dtx++;
    end
    initial
    begin
        #3000000;
        n_mismatch++;
        test_done();
    end
    task automatic test_done();
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= {16'h0000, d};
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready_out !== 1'b1 && n < 10);
        rd = prdata_out;
        check(pready_out, 1'b1);
        check(pslverr_out, a == 8'h3c);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : bus
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        bus(1'b0, a, 16'h0000);
        check(rd & m, e);
    endtask : rchk
    task automatic mx(input logic [15:0] tx, input logic [15:0] rp, input int tog);
        int n;
        reply = rp;
        n_tog = 0;
        sel_n <= 1'b0;
        bus(1'b1, A_DAT, tx);
        for (n = 0; n_tog < tog && n < 2000; n++)
            @(posedge clk_in);
        sel_n <= 1'b1;
        check(32'(n_tog), 32'(tog));
        check(got & {{8{wide}}, 8'hff}, tx & {{8{wide}}, 8'hff});
        @(posedge clk_in);
    endtask : mx
    task automatic sx(input logic [7:0] m);
        int i;
        sel_n <= 1'b0;
        repeat (4) @(posedge clk_in);
        check(so_oe, 1'b1);
        for (i = 7; i >= 0; i--)
        begin
            mo_tb <= m[i];
            repeat (4) @(posedge clk_in);
            sck_tb <= 1'b1;
            so8[i] = so_o;
            repeat (4) @(posedge clk_in);
            sck_tb <= 1'b0;
        end
        repeat (4) @(posedge clk_in);
        sel_n <= 1'b1;
    endtask : sx
    initial
    begin
        {rstn_in, psel_in, penable_in, pwrite_in, sck_tb, mo_tb, phase, wide} = 8'h00;
        sel_n = 1'b1;
        paddr_in = 8'h00;
        pwdata_in = 32'h0;
        reply = 16'h0;
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
        rchk(A_C1, 32'h0);
        rchk(A_C2, 32'h0);
        rchk(A_ST, 32'h0);
        rchk(8'h3c, 32'h0);
        bus(1'b1, A_C1, 16'hfffe);
        rchk(A_C1, 32'hfffe);
        bus(1'b1, A_C2, 16'hffff);
        rchk(A_C2, 32'h3);
        bus(1'b1, A_ST, 16'hfffb);
        rchk(A_ST, 32'h0);
        // Master, 8 bits, configured while off
        bus(1'b1, A_C1, 16'h0232);
        bus(1'b1, A_C1, 16'h0233);
        mx(16'h003c, 16'h00a5, 16);
        rchk(A_ST, 32'h2);
        check(irq, 1'b1);
        check(32'(n_drx), 32'h1);
        check(32'(n_dtx), 32'h1);
        rchk(A_DAT, 32'ha5, 32'hff);
        rchk(A_ST, 32'h0);
        // Overrun on a third word
        mx(16'h0011, 16'h0081, 16);
        mx(16'h0022, 16'h0042, 16);
        rchk(A_ST, 32'h3);
        mx(16'h0033, 16'h0024, 16);
        rchk(A_ST, 32'h7);
        rchk(A_DAT, 32'h81, 32'hff);
        rchk(A_ST, 32'h6);
        rchk(A_DAT, 32'h24, 32'hff);
        rchk(A_ST, 32'h4);
        check(irq, 1'b1);
        bus(1'b1, A_ST, 16'h0003);
        rchk(A_ST, 32'h4);
        bus(1'b1, A_ST, 16'h0004);
        rchk(A_ST, 32'h0);
        // Disable with a word waiting
        mx(16'h0055, 16'h0018, 16);
        bus(1'b1, A_C1, 16'h0232);
        rchk(A_ST, 32'h0);
        check(sck_o, 1'b0);
        // Master, 16 bits, alternate edges, idle high
        bus(1'b1, A_C2, 16'h0003);
        phase = 1'b1;
        wide = 1'b1;
        bus(1'b1, A_C1, 16'h07c6);
        bus(1'b1, A_C1, 16'h07c7);
        mx(16'hbeef, 16'h1234, 32);
        check(32'(int'(t_half / 100.0)), 32'h4);
        rchk(A_ST, 32'h2);
        check(irq, 1'b1);
        check(sck_o, 1'b1);
        rchk(A_DAT, 32'h1234);
        // Slave with valid data
        phase = 1'b0;
        wide = 1'b0;
        bus(1'b1, A_C1, 16'h07c6);
        bus(1'b1, A_C1, 16'h0020);
        bus(1'b1, A_C1, 16'h0021);
        bus(1'b1, A_DAT, 16'h0096);
        rchk(A_ST, 32'h1, 32'h1);
        sx(8'h5a);
        check(so8, 8'h96);
        rchk(A_ST, 32'h2);
        rchk(A_DAT, 32'h5a, 32'hff);
        // Slave echo without data
        bus(1'b1, A_C1, 16'h0020);
        bus(1'b1, A_C1, 16'h0008);
        bus(1'b1, A_C1, 16'h0009);
        sx(8'hc3);
        check(so8[6:0], 7'h61);
        check(irq, 1'b0);
        rchk(A_DAT, 32'hc3, 32'hff);
        test_done();
    end
endmodule : sync_serial_shift_port_test
